/* File: irh_input_route_and_hp_level_regs.sv */
// register bank for right input routing and headphone output level
// assumes one synchronous clock; strobes are single cycle, never both
//
// Implementation choice: the strobed register port.

// Function
// - mode field: 00 single-ended, 01 diff line, 10 diff mic, 11 reserved
// - bit 6 enables common-mode rejection, only in differential line mode
// - bits 5:4 pick inverting pin, non-inverting in mic mode
// - bits 3:2 pick non-inverting pin, inverting in mic mode; reset 01
// - bit 8 of each headphone register mutes its channel; reset 0
// - writing 1 to bit 7 applies both headphone volumes together
// - bit 6 of each headphone register enables zero-cross changes
// - volume code 000000 is -57 dB, 1 dB steps, 111111 is +6 dB
// - reset: volumes 10_1101, mute, zero-cross and update bits clear
module irh_input_route_and_hp_level_regs #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 16
) (
   // clock and reset
   input  wire  logic              i_clk_sys,
   input  wire  logic              i_reset_n,
   // register port
   input  wire  logic [ADDR_W-1:0] i_addr,
   input  wire  logic [DATA_W-1:0] i_wr_data,
   input  wire  logic              i_wr_en,
   input  wire  logic              i_rd_en,
   output logic       [DATA_W-1:0] o_rd_data,
   // right input path
   output logic                    o_right_single_ended,
   output logic                    o_right_diff_line,
   output logic                    o_right_diff_mic,
   output logic                    o_right_cm_reject_en,
   output logic       [2:0]        o_right_inv_pin,
   output logic       [2:0]        o_right_noninv_pin,
   // headphone level
   output logic                    o_hp_left_mute,
   output logic                    o_hp_right_mute,
   output logic                    o_hp_left_zero_cross_en,
   output logic                    o_hp_right_zero_cross_en,
   output logic       [5:0]        o_hp_left_volume,
   output logic       [5:0]        o_hp_right_volume,
   output logic signed [6:0]       o_hp_left_gain_db,
   output logic signed [6:0]       o_hp_right_gain_db,
   output logic                    o_hp_volume_update
);

   // ------------------------------------------------------------
   // stored fields
   // ------------------------------------------------------------
   irh_pkg::irh_mode_t mode_r;
   logic               right_cm_reject_en_r;
   logic [1:0]         right_inv_pin_select_r;
   logic [1:0]         right_noninv_pin_select_r;
   logic               hp_left_mute_r;
   logic               hp_right_mute_r;
   logic               hp_left_zero_cross_en_r;
   logic               hp_right_zero_cross_en_r;
   logic [5:0]         hp_left_volume_r;
   logic [5:0]         hp_right_volume_r;
   logic [5:0]         hp_left_volume_nxt;
   logic [5:0]         hp_right_volume_nxt;
   logic [DATA_W-1:0]  rd_data_nxt;

   logic wr_ric;
   logic wr_hpl;
   logic wr_hpr;
   logic vu_wr;
   logic wr_mute_bit;
   logic wr_zc_bit;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   assign wr_ric = i_wr_en && (i_addr == ADDR_W'(irh_pkg::RIC_ADDR));
   assign wr_hpl = i_wr_en && (i_addr == ADDR_W'(irh_pkg::HPL_ADDR));
   assign wr_hpr = i_wr_en && (i_addr == ADDR_W'(irh_pkg::HPR_ADDR));
   assign vu_wr  = (wr_hpl || wr_hpr) && i_wr_data[irh_pkg::VU_BIT];
   assign wr_mute_bit = i_wr_data[irh_pkg::MUTE_BIT];
   assign wr_zc_bit   = i_wr_data[irh_pkg::ZC_BIT];

   // pin select: 00 pin one, 01 pin two, 1x pin three
   function automatic logic [2:0] pin_onehot(input logic [1:0] sel);
      return sel[1] ? 3'h4 : (sel[0] ? 3'h2 : 3'h1);
   endfunction

   // ------------------------------------------------------------
   // right input configuration register
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mode_r                    <= irh_pkg::MODE_RST;
         right_cm_reject_en_r      <= irh_pkg::CM_RST;
         right_inv_pin_select_r    <= irh_pkg::INV_RST;
         right_noninv_pin_select_r <= irh_pkg::NINV_RST;
      end else if (wr_ric) begin
         mode_r <= irh_pkg::irh_mode_t'(
            i_wr_data[irh_pkg::MODE_LSB +: 2]);
         right_cm_reject_en_r <= i_wr_data[irh_pkg::CM_BIT];
         right_inv_pin_select_r <=
            i_wr_data[irh_pkg::INV_LSB +: 2];
         right_noninv_pin_select_r <=
            i_wr_data[irh_pkg::NINV_LSB +: 2];
      end
   end

   // ------------------------------------------------------------
   // right path decode
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_right_single_ended <= 1'h1;
         o_right_diff_line    <= 1'h0;
         o_right_diff_mic     <= 1'h0;
      end else begin
         o_right_single_ended <= 1'h0;
         o_right_diff_line    <= 1'h0;
         o_right_diff_mic     <= 1'h0;
         case (mode_r)
            irh_pkg::IRH_MODE_SE: begin
               o_right_single_ended <= 1'h1;
            end
            irh_pkg::IRH_MODE_DLINE: begin
               o_right_diff_line <= 1'h1;
            end
            irh_pkg::IRH_MODE_DMIC: begin
               o_right_diff_mic <= 1'h1;
            end
            default: begin
               // reserved code selects no mode
            end
         endcase
      end
   end

   // rejection only meaningful for differential line input
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_right_cm_reject_en <= 1'h0;
      end else begin
         o_right_cm_reject_en <= right_cm_reject_en_r &&
            (mode_r == irh_pkg::IRH_MODE_DLINE);
      end
   end

   // mic mode swaps which field drives which amplifier side
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_right_inv_pin    <= 3'h1;
         o_right_noninv_pin <= 3'h2;
      end else if (mode_r == irh_pkg::IRH_MODE_DMIC) begin
         o_right_inv_pin    <= pin_onehot(right_noninv_pin_select_r);
         o_right_noninv_pin <= pin_onehot(right_inv_pin_select_r);
      end else begin
         o_right_inv_pin    <= pin_onehot(right_inv_pin_select_r);
         o_right_noninv_pin <= pin_onehot(right_noninv_pin_select_r);
      end
   end

   // ------------------------------------------------------------
   // headphone level registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hp_left_mute_r          <= irh_pkg::MUTE_RST;
         hp_left_zero_cross_en_r <= irh_pkg::ZC_RST;
      end else if (wr_hpl) begin
         hp_left_mute_r          <= wr_mute_bit;
         hp_left_zero_cross_en_r <= wr_zc_bit;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hp_right_mute_r          <= irh_pkg::MUTE_RST;
         hp_right_zero_cross_en_r <= irh_pkg::ZC_RST;
      end else if (wr_hpr) begin
         hp_right_mute_r          <= wr_mute_bit;
         hp_right_zero_cross_en_r <= wr_zc_bit;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_hp_left_mute           <= irh_pkg::MUTE_RST;
         o_hp_right_mute          <= irh_pkg::MUTE_RST;
         o_hp_left_zero_cross_en  <= irh_pkg::ZC_RST;
         o_hp_right_zero_cross_en <= irh_pkg::ZC_RST;
      end else begin
         o_hp_left_mute           <= hp_left_mute_r;
         o_hp_right_mute          <= hp_right_mute_r;
         o_hp_left_zero_cross_en  <= hp_left_zero_cross_en_r;
         o_hp_right_zero_cross_en <= hp_right_zero_cross_en_r;
      end
   end

   // ------------------------------------------------------------
   // pending and applied volumes
   // ------------------------------------------------------------
   always_comb begin
      hp_left_volume_nxt  = hp_left_volume_r;
      hp_right_volume_nxt = hp_right_volume_r;
      if (wr_hpl) begin
         hp_left_volume_nxt = i_wr_data[irh_pkg::VOL_LSB +: 6];
      end
      if (wr_hpr) begin
         hp_right_volume_nxt = i_wr_data[irh_pkg::VOL_LSB +: 6];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hp_left_volume_r  <= irh_pkg::VOL_RST;
         hp_right_volume_r <= irh_pkg::VOL_RST;
      end else begin
         hp_left_volume_r  <= hp_left_volume_nxt;
         hp_right_volume_r <= hp_right_volume_nxt;
      end
   end

   // both channels load in the same edge, including this write's value
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_hp_left_volume   <= irh_pkg::VOL_RST;
         o_hp_right_volume  <= irh_pkg::VOL_RST;
         o_hp_left_gain_db  <= 7'({1'b0, irh_pkg::VOL_RST}
                                  - irh_pkg::VOL_0DB);
         o_hp_right_gain_db <= 7'({1'b0, irh_pkg::VOL_RST}
                                  - irh_pkg::VOL_0DB);
      end else if (vu_wr) begin
         o_hp_left_volume   <= hp_left_volume_nxt;
         o_hp_right_volume  <= hp_right_volume_nxt;
         o_hp_left_gain_db  <= 7'({1'b0, hp_left_volume_nxt}
                                  - irh_pkg::VOL_0DB);
         o_hp_right_gain_db <= 7'({1'b0, hp_right_volume_nxt}
                                  - irh_pkg::VOL_0DB);
      end
   end

   // one-cycle notice to the amplifiers that new levels are loaded
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_hp_volume_update <= 1'h0;
      end else begin
         o_hp_volume_update <= vu_wr;
      end
   end

   // ------------------------------------------------------------
   // readback
   // ------------------------------------------------------------
   always_comb begin
      rd_data_nxt = '0;
      if (i_addr == ADDR_W'(irh_pkg::RIC_ADDR)) begin
         rd_data_nxt[irh_pkg::CM_BIT]        = right_cm_reject_en_r;
         rd_data_nxt[irh_pkg::INV_LSB +: 2]  = right_inv_pin_select_r;
         rd_data_nxt[irh_pkg::NINV_LSB +: 2] = right_noninv_pin_select_r;
         rd_data_nxt[irh_pkg::MODE_LSB +: 2] = mode_r;
      end else if (i_addr == ADDR_W'(irh_pkg::HPL_ADDR)) begin
         rd_data_nxt[irh_pkg::MUTE_BIT]     = hp_left_mute_r;
         rd_data_nxt[irh_pkg::ZC_BIT]       = hp_left_zero_cross_en_r;
         rd_data_nxt[irh_pkg::VOL_LSB +: 6] = hp_left_volume_r;
      end else if (i_addr == ADDR_W'(irh_pkg::HPR_ADDR)) begin
         rd_data_nxt[irh_pkg::MUTE_BIT]     = hp_right_mute_r;
         rd_data_nxt[irh_pkg::ZC_BIT]       = hp_right_zero_cross_en_r;
         rd_data_nxt[irh_pkg::VOL_LSB +: 6] = hp_right_volume_r;
      end
   end

   // update bit is never stored, so it reads as zero
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rd_data <= '0;
      end else if (i_rd_en) begin
         o_rd_data <= rd_data_nxt;
      end else begin
         o_rd_data <= '0;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_mode_mic;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (mode_r == irh_pkg::IRH_MODE_DMIC) |=>
         o_right_diff_mic && !o_right_diff_line && !o_right_single_ended;
   endproperty
   a_mode_mic: assert property (p_mode_mic)
      else $error("mic mode not decoded");

   property p_cm_gate;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (mode_r != irh_pkg::IRH_MODE_DLINE) |=> !o_right_cm_reject_en;
   endproperty
   a_cm_gate: assert property (p_cm_gate)
      else $error("rejection active outside diff line");

   property p_inv_swap;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (mode_r == irh_pkg::IRH_MODE_DMIC) |=>
         o_right_noninv_pin == pin_onehot($past(right_inv_pin_select_r));
   endproperty
   a_inv_swap: assert property (p_inv_swap)
      else $error("mic mode pin swap wrong");

   property p_noninv_plain;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (mode_r != irh_pkg::IRH_MODE_DMIC) |=>
         o_right_noninv_pin == pin_onehot($past(right_noninv_pin_select_r));
   endproperty
   a_noninv_plain: assert property (p_noninv_plain)
      else $error("non-inverting pin wrong");

   property p_left_mute;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      wr_hpl ##1 !wr_hpl |=> o_hp_left_mute == $past(wr_mute_bit, 2);
   endproperty
   a_left_mute: assert property (p_left_mute)
      else $error("left mute not applied");

   property p_right_zc;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      wr_hpr ##1 !wr_hpr |=>
         o_hp_right_zero_cross_en == $past(wr_zc_bit, 2);
   endproperty
   a_right_zc: assert property (p_right_zc)
      else $error("right zero-cross not applied");

   property p_vu_both;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      vu_wr |=> (o_hp_left_volume == hp_left_volume_r) &&
         (o_hp_right_volume == hp_right_volume_r) && o_hp_volume_update;
   endproperty
   a_vu_both: assert property (p_vu_both)
      else $error("volumes not applied together");

   property p_pending_hold;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      !vu_wr |=> $stable(o_hp_left_volume) && $stable(o_hp_right_volume);
   endproperty
   a_pending_hold: assert property (p_pending_hold)
      else $error("volume changed without update");

   property p_gain_0db;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      (o_hp_left_volume == 6'(irh_pkg::VOL_0DB)) |->
         (o_hp_left_gain_db == 7'sh00);
   endproperty
   a_gain_0db: assert property (p_gain_0db)
      else $error("0 dB code gives wrong gain");

   property p_vu_reads_zero;
      @(posedge i_clk_sys) disable iff (!i_reset_n)
      i_rd_en |=> !o_rd_data[irh_pkg::VU_BIT];
   endproperty
   a_vu_reads_zero: assert property (p_vu_reads_zero)
      else $error("update bit reads back set");

   c_mic_mode: cover property (@(posedge i_clk_sys)
      disable iff (!i_reset_n) wr_ric ##2 o_right_diff_mic);
   c_vu_write: cover property (@(posedge i_clk_sys)
      disable iff (!i_reset_n) vu_wr ##1 o_hp_volume_update);
   c_pend_then_vu: cover property (@(posedge i_clk_sys)
      disable iff (!i_reset_n) (wr_hpl && !vu_wr) ##[1:4] vu_wr);

endmodule

/* File: irh_input_route_and_hp_level_regs_test.sv */
// self-checking bench for the right input routing and headphone level regs
// assumes irh_pkg is compiled first; the bench alone drives the register port
module irh_input_route_and_hp_level_regs_test;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // design signals
   // ------------------------------------------------------------
   logic              i_clk_sys;
   logic              i_reset_n;
   logic [7:0]        i_addr;
   logic [15:0]       i_wr_data;
   logic              i_wr_en;
   logic              i_rd_en;
   logic [15:0]       o_rd_data;
   logic              o_right_single_ended;
   logic              o_right_diff_line;
   logic              o_right_diff_mic;
   logic              o_right_cm_reject_en;
   logic [2:0]        o_right_inv_pin;
   logic [2:0]        o_right_noninv_pin;
   logic              o_hp_left_mute;
   logic              o_hp_right_mute;
   logic              o_hp_left_zero_cross_en;
   logic              o_hp_right_zero_cross_en;
   logic [5:0]        o_hp_left_volume;
   logic [5:0]        o_hp_right_volume;
   logic signed [6:0] o_hp_left_gain_db;
   logic signed [6:0] o_hp_right_gain_db;
   logic              o_hp_volume_update;

   // ------------------------------------------------------------
   // model state
   // ------------------------------------------------------------
   int          errors;
   int          checks;
   int          i;
   int          k;
   logic [31:0] seed;
   logic [6:0]  ric, lric;
   logic        ml, mr, zl, zr, lml, lmr, lzl, lzr;
   logic [5:0]  pl, pr, al, ar;
   logic [15:0] exp_rd;
   logic        exp_upd;
   logic        pw, prd;
   logic [7:0]  pa;
   logic [15:0] pd;
   logic [7:0]  addr_tab [8];
   logic [15:0] hp_tab [6];

   irh_input_route_and_hp_level_regs DUT (
      .i_clk_sys                (i_clk_sys),
      .i_reset_n                (i_reset_n),
      .i_addr                   (i_addr),
      .i_wr_data                (i_wr_data),
      .i_wr_en                  (i_wr_en),
      .i_rd_en                  (i_rd_en),
      .o_rd_data                (o_rd_data),
      .o_right_single_ended     (o_right_single_ended),
      .o_right_diff_line        (o_right_diff_line),
      .o_right_diff_mic         (o_right_diff_mic),
      .o_right_cm_reject_en     (o_right_cm_reject_en),
      .o_right_inv_pin          (o_right_inv_pin),
      .o_right_noninv_pin       (o_right_noninv_pin),
      .o_hp_left_mute           (o_hp_left_mute),
      .o_hp_right_mute          (o_hp_right_mute),
      .o_hp_left_zero_cross_en  (o_hp_left_zero_cross_en),
      .o_hp_right_zero_cross_en (o_hp_right_zero_cross_en),
      .o_hp_left_volume         (o_hp_left_volume),
      .o_hp_right_volume        (o_hp_right_volume),
      .o_hp_left_gain_db        (o_hp_left_gain_db),
      .o_hp_right_gain_db       (o_hp_right_gain_db),
      .o_hp_volume_update       (o_hp_volume_update)
   );

   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   function automatic logic [2:0] oh(input logic [1:0] s);
      return (s == 2'h0) ? 3'h1 : ((s == 2'h1) ? 3'h2 : 3'h4);
   endfunction

   function automatic logic [6:0] gdb(input logic [5:0] v);
      return 7'(int'(v) - 57);
   endfunction

   task automatic complete_run;
      if (errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic compare;
      logic [1:0] m;
      logic       dm;
      logic [2:0] ni;
      logic [2:0] pi;
      m = lric[1:0];
      dm = (m == 2'h2);
      ni = oh(lric[5:4]);
      pi = oh(lric[3:2]);
      chk(o_rd_data, exp_rd);
      chk(16'({o_right_single_ended, o_right_diff_line,
               o_right_diff_mic}), 16'({m == 2'h0, m == 2'h1, dm}));
      chk(16'(o_right_cm_reject_en), 16'(lric[6] & (m == 2'h1)));
      chk(16'(o_right_inv_pin), 16'(dm ? pi : ni));
      chk(16'(o_right_noninv_pin), 16'(dm ? ni : pi));
      chk(16'({o_hp_left_mute, o_hp_right_mute}), 16'({lml, lmr}));
      chk(16'({o_hp_left_zero_cross_en, o_hp_right_zero_cross_en}),
          16'({lzl, lzr}));
      chk(16'({o_hp_left_volume, o_hp_right_volume}), 16'({al, ar}));
      chk(16'({o_hp_left_gain_db, o_hp_right_gain_db}),
          16'({gdb(al), gdb(ar)}));
      chk(16'(o_hp_volume_update), 16'(exp_upd));
   endtask

   task automatic mreset;
      ric = 7'h44;
      {ml, mr, zl, zr} = 4'h0;
      pl = irh_pkg::VOL_RST;
      pr = irh_pkg::VOL_RST;
      al = irh_pkg::VOL_RST;
      ar = irh_pkg::VOL_RST;
      {lric, lml, lmr, lzl, lzr} = {ric, 4'h0};
      exp_rd = 16'h0;
      exp_upd = 1'b0;
      pw = 1'b0;
      prd = 1'b0;
   endtask

   // model of the request taken at this edge
   task automatic step;
      {lric, lml, lmr, lzl, lzr} = {ric, ml, mr, zl, zr};
      exp_rd = 16'h0;
      exp_upd = 1'b0;
      if (prd) begin
         case (pa)
            irh_pkg::RIC_ADDR: exp_rd = 16'(ric);
            irh_pkg::HPL_ADDR: exp_rd = {7'h0, ml, 1'b0, zl, pl};
            irh_pkg::HPR_ADDR: exp_rd = {7'h0, mr, 1'b0, zr, pr};
            default: exp_rd = 16'h0;
         endcase
      end
      if (pw && pa == irh_pkg::RIC_ADDR) begin
         ric = pd[6:0];
      end
      if (pw && pa == irh_pkg::HPL_ADDR) begin
         {ml, zl, pl} = {pd[8], pd[6], pd[5:0]};
      end
      if (pw && pa == irh_pkg::HPR_ADDR) begin
         {mr, zr, pr} = {pd[8], pd[6], pd[5:0]};
      end
      if (pw && pd[7] && (pa == irh_pkg::HPL_ADDR || pa == irh_pkg::HPR_ADDR))
      begin
         al = pl;
         ar = pr;
         exp_upd = 1'b1;
      end
   endtask

   task automatic cyc(input logic w, input logic r, input logic [7:0] a,
                      input logic [15:0] d);
      @(posedge i_clk_sys);
      step;
      i_wr_en <= w;
      i_rd_en <= r;
      i_addr <= a;
      i_wr_data <= d;
      {pw, prd, pa, pd} = {w, r, a, d};
      #1;
      compare;
   endtask

   task automatic do_reset;
      @(posedge i_clk_sys);
      i_reset_n <= 1'b0;
      i_wr_en <= 1'b0;
      i_rd_en <= 1'b0;
      mreset;
      #1;
      compare;
      repeat (8) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      errors = 0;
      checks = 0;
      seed = 32'hD1495FB8;
      {i_reset_n, i_wr_en, i_rd_en, i_addr, i_wr_data} = '0;
      addr_tab = '{8'h2F, 8'h39, 8'h3A, 8'h2F, 8'h39, 8'h3A, 8'h3B, 8'h00};
      hp_tab = '{16'h0080, 16'h01C0, 16'h00B9, 16'h0040, 16'h00BF, 16'h0100};
      do_reset;
      for (k = 0; k < 3; k++) begin
         cyc(1'b0, 1'b1, addr_tab[k], 16'h0);
      end
      for (i = 0; i < 128; i++) begin
         seed = xs(seed);
         cyc(1'b1, 1'b0, irh_pkg::RIC_ADDR, {seed[15:7], 7'(i)});
         cyc(1'b0, 1'b1, irh_pkg::RIC_ADDR, 16'h0);
         cyc(1'b0, 1'b0, 8'h00, 16'h0);
      end
      // pending left volume, then update from the right register
      cyc(1'b1, 1'b0, irh_pkg::HPL_ADDR, 16'h0010);
      cyc(1'b1, 1'b0, irh_pkg::HPR_ADDR, 16'h00A0);
      cyc(1'b0, 1'b1, irh_pkg::HPR_ADDR, 16'h0);
      for (k = 0; k < 6; k++) begin
         cyc(1'b1, 1'b0, irh_pkg::HPL_ADDR, hp_tab[k]);
         cyc(1'b1, 1'b0, irh_pkg::HPR_ADDR, hp_tab[5 - k]);
         cyc(1'b0, 1'b1, irh_pkg::HPL_ADDR, 16'h0);
         cyc(1'b0, 1'b1, irh_pkg::HPR_ADDR, 16'h0);
         cyc(1'b0, 1'b0, 8'h00, 16'h0);
      end
      // random back-to-back traffic, unmapped addresses included
      repeat (400) begin
         seed = xs(seed);
         cyc(seed[0], seed[1] & ~seed[0], addr_tab[seed[4:2]], seed[31:16]);
      end
      do_reset;
      cyc(1'b0, 1'b1, irh_pkg::RIC_ADDR, 16'h0);
      cyc(1'b0, 1'b1, irh_pkg::HPL_ADDR, 16'h0);
      repeat (3) cyc(1'b0, 1'b0, 8'h00, 16'h0);
      complete_run;
   end

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      errors++;
      complete_run;
   end

endmodule

/* File: irh_pkg.sv */
// constants for the right input routing and headphone level registers
// assumes a byte-addressed control port with 16-bit register data
package irh_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] RIC_ADDR = 8'h2F;
   localparam logic [7:0] HPL_ADDR = 8'h39;
   localparam logic [7:0] HPR_ADDR = 8'h3A;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CM_BIT   = 6;
   localparam int INV_LSB  = 4;
   localparam int NINV_LSB = 2;
   localparam int MODE_LSB = 0;
   localparam int MUTE_BIT = 8;
   localparam int VU_BIT   = 7;
   localparam int ZC_BIT   = 6;
   localparam int VOL_LSB  = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic       CM_RST   = 1'h1;
   localparam logic [1:0] INV_RST  = 2'h0;
   localparam logic [1:0] NINV_RST = 2'h1;
   localparam logic       MUTE_RST = 1'h0;
   localparam logic       ZC_RST   = 1'h0;
   localparam logic [5:0] VOL_RST  = 6'h2D;

   // volume code that gives 0 dB; 1 dB per step
   localparam logic [6:0] VOL_0DB  = 7'h39;

   // ------------------------------------------------------------
   // right input modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      IRH_MODE_SE    = 2'b00,
      IRH_MODE_DLINE = 2'b01,
      IRH_MODE_DMIC  = 2'b10,
      IRH_MODE_RSVD  = 2'b11
   } irh_mode_t;

   localparam irh_mode_t MODE_RST = IRH_MODE_SE;

endpackage
